// [logic/qwsp_device.sv]
// qwsp_device: five-wire shift port and four volatile wiper registers
// assumes: link pins are asynchronous and are synchronised on core_clk
// assumes: every pin edge is seen three core clocks late, so the host
//   keeps each serial clock phase at least five core clocks long
// assumes: all link pins idle low after reset
`timescale 1ns/1ns
`default_nettype none
// Function
// - all wipers reset to mid value 32
// - wiper 63 high end, 0 low end
// - word: index in top two, value below
// - five-wire port active only when select low
// - MSB first, whole eight-bit words
// - enable rise starts, transfer only while high
// - direction sampled at enable rise only
// - write captures data on clock rise
// - eighth clock fall loads addressed wiper
// - one to four bytes, any order
// - enable fall ends transaction
// - cascade held low during write
// - enable low: cascade follows data in
// - read bits change after clock fall
// - read MSB first from pot 0 upward
// - select high: five-wire port ignores pins
module qwsp_device (
  input wire logic core_clk,
  input wire logic reset,
  qwsp_link_if.device link,
  output logic [5:0] wiperPos0_q,
  output logic [5:0] wiperPos1_q,
  output logic [5:0] wiperPos2_q,
  output logic [5:0] wiperPos3_q,
  output logic atHighEnd0_q,
  output logic atLowEnd0_q
);
  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers
  // bit order: select, enable, direction, clock, data
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [4:0] pinPrev_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta_q <= 5'h00;
      pinSync_q <= 5'h00;
      pinPrev_q <= 5'h00;
    end else begin
      pinMeta_q <= {link.portSelect, link.xferEnable, link.readNotWrite,
                    link.serClk, link.dataIn};
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end
  logic selSync;
  logic enSync;
  logic dirSync;
  logic sclkSync;
  logic dinSync;
  assign {selSync, enSync, dirSync, sclkSync, dinSync} = pinSync_q;
  // previous synchronised levels, for edge detection
  logic enPrev;
  logic sclkPrev;
  assign enPrev = pinPrev_q[3];
  assign sclkPrev = pinPrev_q[1];
  logic portOn;
  assign portOn = ~selSync;
  // enable rise and clock edges count only while this port is selected
  logic enRise;
  logic enFall;
  logic clkRise;
  logic clkFall;
  assign enRise = portOn & enSync & ~enPrev;
  assign enFall = ~enSync & enPrev;
  assign clkRise = portOn & enSync & sclkSync & ~sclkPrev;
  assign clkFall = portOn & enSync & ~sclkSync & sclkPrev;

  ////////////////////////////////////////////////////////////////////////
  // transaction state
  logic active_q;
  logic readMode_q;
  always_ff @(posedge core_clk) begin
    if (reset || enFall || !portOn) begin
      active_q <= 1'b0;
    end else if (enRise) begin
      active_q <= 1'b1;
    end
  end
  // direction is latched once per frame; later moves are ignored
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readMode_q <= 1'b0;
    end else if (enRise) begin
      readMode_q <= dirSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write shift path
  logic [7:0] shift_q;
  logic [2:0] bitCnt_q;
  logic byteDone_q;
  // byteDone marks the eighth rise; the next fall loads the wiper
  // a partial byte is dropped when the frame ends
  always_ff @(posedge core_clk) begin
    if (reset || enRise || !active_q) begin
      shift_q <= 8'h00;
      bitCnt_q <= 3'h0;
      byteDone_q <= 1'b0;
    end else if (!readMode_q && clkRise) begin
      shift_q <= {shift_q[6:0], dinSync};
      bitCnt_q <= bitCnt_q + 3'h1;
      byteDone_q <= (bitCnt_q == qwsp_pkg::LAST_BIT);
    end else if (clkFall) begin
      byteDone_q <= 1'b0;
    end
  end
  logic loadNow;
  assign loadNow = active_q & ~readMode_q & clkFall & byteDone_q;
  logic [1:0] loadIdx;
  logic [5:0] loadVal;
  assign loadIdx = shift_q[7:6];
  assign loadVal = shift_q[5:0];

  ////////////////////////////////////////////////////////////////////////
  // wiper registers
  // volatile: every reset returns the wipers to mid position
  logic [5:0] wiper_q [qwsp_pkg::WIPER_COUNT];
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < qwsp_pkg::WIPER_COUNT; i++) begin
        wiper_q[i] <= qwsp_pkg::WIPER_RESET;
      end
    end else if (loadNow) begin
      wiper_q[loadIdx] <= loadVal;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wiperPos0_q <= qwsp_pkg::WIPER_RESET;
      wiperPos1_q <= qwsp_pkg::WIPER_RESET;
      wiperPos2_q <= qwsp_pkg::WIPER_RESET;
      wiperPos3_q <= qwsp_pkg::WIPER_RESET;
    end else begin
      wiperPos0_q <= wiper_q[0];
      wiperPos1_q <= wiper_q[1];
      wiperPos2_q <= wiper_q[2];
      wiperPos3_q <= wiper_q[3];
    end
  end
  // end flags stand for the end-terminal connections of pot 0
  always_ff @(posedge core_clk) begin
    if (reset) begin
      atHighEnd0_q <= 1'b0;
      atLowEnd0_q <= 1'b0;
    end else begin
      atHighEnd0_q <= (wiper_q[0] == qwsp_pkg::WIPER_HIGH_END);
      atLowEnd0_q <= (wiper_q[0] == qwsp_pkg::WIPER_LOW_END);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read shift path
  logic [7:0] rdShift_q;
  logic [2:0] rdCnt_q;
  logic [1:0] rdIdx_q;
  logic rdPrimed_q;
  // pot 0 is preloaded at frame start so its MSB leads
  always_ff @(posedge core_clk) begin
    if (reset || !active_q || !readMode_q) begin
      rdShift_q <= 8'h00;
      rdCnt_q <= 3'h0;
      rdIdx_q <= qwsp_pkg::FIRST_POT;
      rdPrimed_q <= 1'b0;
    end else if (!rdPrimed_q) begin
      rdShift_q <= {qwsp_pkg::FIRST_POT, wiper_q[0]};
      rdIdx_q <= qwsp_pkg::FIRST_POT + 2'h1;
      rdPrimed_q <= 1'b1;
    end else if (clkFall) begin
      rdCnt_q <= rdCnt_q + 3'h1;
      if (rdCnt_q == qwsp_pkg::LAST_BIT) begin
        rdShift_q <= {rdIdx_q, wiper_q[rdIdx_q]};
        // index wraps from pot 3 back to pot 0
        rdIdx_q <= rdIdx_q + 2'h1;
      end else begin
        rdShift_q <= {rdShift_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cascade output
  logic cascade_q;
  // bypass while idle or while the other port is selected
  // read data leads only once the shifter is primed
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cascade_q <= 1'b0;
    end else if (!enSync || !portOn) begin
      cascade_q <= dinSync;
    end else if (active_q && readMode_q && rdPrimed_q) begin
      cascade_q <= rdShift_q[7];
    end else begin
      cascade_q <= 1'b0;
    end
  end
  assign link.cascadeOut = cascade_q;
endmodule
`default_nettype wire

// [logic/qwsp_host.sv]
// qwsp_host: host controller driving the five-wire shift port
// assumes: user pulses start with the word count; link clock made here
`timescale 1ns/1ns
`default_nettype none
module qwsp_host (
  input wire logic core_clk,
  input wire logic reset,
  qwsp_link_if.host link,
  input wire logic start,
  input wire logic readOp,
  input wire logic [1:0] wordCountM1,
  input wire logic [31:0] writeWords,
  output logic busy_q,
  output logic done_q,
  output logic [31:0] readWords_q
);
  ////////////////////////////////////////////////////////////////////////
  // cascade input synchroniser
  logic casMeta_q;
  logic casSync_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      casMeta_q <= 1'b0;
      casSync_q <= 1'b0;
    end else begin
      casMeta_q <= link.cascadeOut;
      casSync_q <= casMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  qwsp_pkg::qwsp_host_state_t state_q;
  logic [3:0] tick_q;
  logic [4:0] bitsLeft_q;
  logic [31:0] txShift_q;
  logic dir_q;
  logic en_q;
  logic sclk_q;
  logic dout_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= qwsp_pkg::HS_IDLE;
      tick_q <= 4'h0;
      bitsLeft_q <= 5'h00;
      txShift_q <= 32'h0000_0000;
      dir_q <= 1'b0;
      en_q <= 1'b0;
      sclk_q <= 1'b0;
      dout_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      readWords_q <= 32'h0000_0000;
    end else begin
      done_q <= 1'b0;
      tick_q <= tick_q + 4'h1;
      case (state_q)
        qwsp_pkg::HS_IDLE: begin
          tick_q <= 4'h0;
          if (start) begin
            // direction set before enable rises
            dir_q <= readOp;
            // first data bit leads enable
            dout_q <= writeWords[{wordCountM1, 3'h7}];
            txShift_q <= writeWords << (8 * (3 - int'(wordCountM1)));
            bitsLeft_q <= {wordCountM1, 3'h7};
            busy_q <= 1'b1;
            state_q <= qwsp_pkg::HS_SETUP;
          end
        end
        qwsp_pkg::HS_SETUP: begin
          if (tick_q == qwsp_pkg::GUARD_LAST) begin
            en_q <= 1'b1;
            dout_q <= txShift_q[31];
            tick_q <= 4'h0;
            state_q <= qwsp_pkg::HS_LOW;
          end
        end
        qwsp_pkg::HS_LOW: begin
          if (tick_q == qwsp_pkg::HALF_LAST) begin
            sclk_q <= 1'b1;
            tick_q <= 4'h0;
            state_q <= qwsp_pkg::HS_HIGH;
          end
        end
        qwsp_pkg::HS_HIGH: begin
          if (tick_q == qwsp_pkg::HALF_LAST) begin
            // sample read bit late in high phase, then fall
            sclk_q <= 1'b0;
            tick_q <= 4'h0;
            readWords_q <= {readWords_q[30:0], casSync_q};
            txShift_q <= {txShift_q[30:0], 1'b0};
            dout_q <= txShift_q[30];
            bitsLeft_q <= bitsLeft_q - 5'h01;
            state_q <= (bitsLeft_q == 5'h00) ? qwsp_pkg::HS_TAIL
                                             : qwsp_pkg::HS_LOW;
          end
        end
        qwsp_pkg::HS_TAIL: begin
          if (tick_q == qwsp_pkg::GUARD_LAST) begin
            en_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            state_q <= qwsp_pkg::HS_IDLE;
          end
        end
        default: state_q <= qwsp_pkg::HS_IDLE;
      endcase
    end
  end
  assign link.portSelect = 1'b0;
  assign link.xferEnable = en_q;
  assign link.readNotWrite = dir_q;
  assign link.serClk = sclk_q;
  assign link.dataIn = dout_q;
endmodule
`default_nettype wire

// [logic/qwsp_link_if.sv]
// qwsp_link_if: the six pins between host and potentiometer device
// assumes: host drives all but the cascade output, which the device drives
`timescale 1ns/1ns
`default_nettype none
interface qwsp_link_if;
  logic portSelect;
  logic xferEnable;
  logic readNotWrite;
  logic serClk;
  logic dataIn;
  logic cascadeOut;
  modport device (
    input portSelect,
    input xferEnable,
    input readNotWrite,
    input serClk,
    input dataIn,
    output cascadeOut
  );
  modport host (
    output portSelect,
    output xferEnable,
    output readNotWrite,
    output serClk,
    output dataIn,
    input cascadeOut
  );
endinterface
`default_nettype wire

// [logic/qwsp_pkg.sv]
// qwsp_pkg: shared constants for the five-wire wiper shift port
// assumes: both ends use these by scoped name; the bench uses its own literals
`default_nettype none
package qwsp_pkg;
  localparam int WIPER_COUNT = 4;
  localparam int WIPER_BITS = 6;
  localparam int INDEX_BITS = 2;
  localparam int WORD_BITS = 8;
  localparam logic [5:0] WIPER_RESET = 6'h20;
  localparam logic [5:0] WIPER_HIGH_END = 6'h3f;
  localparam logic [5:0] WIPER_LOW_END = 6'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] FIRST_POT = 2'h0;
  // host serial clock half period in ns, rounded up to core clocks (divider)
  localparam int CLK_HALF_NS = 80;
  localparam int CORE_NS = 10;
  localparam int CLK_HALF_CYCLES = (CLK_HALF_NS + CORE_NS - 1) / CORE_NS;
  localparam logic [3:0] HALF_LAST = 4'(CLK_HALF_CYCLES - 1);
  // enable setup/hold around frames, in core clocks
  localparam logic [3:0] GUARD_LAST = 4'h8;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SETUP = 3'b001,
    HS_LOW = 3'b010,
    HS_HIGH = 3'b011,
    HS_TAIL = 3'b100
  } qwsp_host_state_t;
endpackage
`default_nettype wire

// [tb/qwsp_link_properties.sv]
// qwsp_link_properties: concurrent checks on the six link pins
// assumes: instantiated beside the link interface, core_clk domain only
`timescale 1ns/1ns
`default_nettype none
module qwsp_link_properties (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic portSelect,
  input wire logic xferEnable,
  input wire logic readNotWrite,
  input wire logic serClk,
  input wire logic dataIn,
  input wire logic cascadeOut
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic serClkPrev_q;
  logic [5:0] riseCnt_q;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    serClkPrev_q <= serClk;
  end
  // serial clock rises seen in the current frame
  always_ff @(posedge core_clk) begin
    if (reset || !xferEnable) begin
      riseCnt_q <= 6'h00;
    end else if (serClk && !serClkPrev_q) begin
      riseCnt_q <= riseCnt_q + 6'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  port_select_a: assert property (!portSelect)
    else $error("port select left high");
  idle_follow_a: assert property (
    (!xferEnable && $stable(dataIn))[*5] |-> cascadeOut == dataIn)
    else $error("cascade not following data in while idle");
  write_quiet_a: assert property (
    (xferEnable && !readNotWrite)[*5] |-> !cascadeOut)
    else $error("cascade active during write");
  dir_hold_a: assert property (xferEnable |-> $stable(readNotWrite))
    else $error("direction moved inside frame");
  clk_framed_a: assert property (!xferEnable |-> !serClk)
    else $error("serial clock outside frame");
  clk_high_a: assert property (
    $rose(serClk) |-> serClk[*8] ##1 !serClk)
    else $error("serial clock high phase wrong");
  data_hold_a: assert property (
    serClk && $past(serClk) |-> $stable(dataIn))
    else $error("data moved while clock high");
  whole_bytes_a: assert property ($fell(xferEnable) |->
    riseCnt_q[2:0] == 3'h0 && riseCnt_q != 6'h00 && riseCnt_q <= 6'h20)
    else $error("frame not whole bytes");
endmodule
`default_nettype wire

// [tb/tb_quad_wiper_shift_port.sv]
// tb_quad_wiper_shift_port: host and device joined, checked against a model
// assumes: host drives the link; device wipers are visible as ports
`timescale 1ns/1ns
`default_nettype none
module tb_quad_wiper_shift_port;
  logic core_clk;
  logic reset;
  logic start;
  logic readOp;
  logic [1:0] wordCountM1;
  logic [31:0] writeWords;
  logic busy;
  logic done;
  logic [31:0] readWords;
  logic [5:0] wp0, wp1, wp2, wp3;
  logic atHigh, atLow;
  int err_total;
  int checks_done;
  int model [4];
  logic [7:0] wireQ [$];
  logic [7:0] wireSh;
  logic clkPrev;
  int nBits;
  qwsp_link_if i_qwsp_link_if ();
  qwsp_host i_qwsp_host (.core_clk(core_clk), .reset(reset),
    .link(i_qwsp_link_if), .start(start), .readOp(readOp),
    .wordCountM1(wordCountM1), .writeWords(writeWords), .busy_q(busy),
    .done_q(done), .readWords_q(readWords));
  qwsp_device i_qwsp_device (.core_clk(core_clk), .reset(reset),
    .link(i_qwsp_link_if), .wiperPos0_q(wp0), .wiperPos1_q(wp1),
    .wiperPos2_q(wp2), .wiperPos3_q(wp3), .atHighEnd0_q(atHigh),
    .atLowEnd0_q(atLow));
  qwsp_link_properties i_qwsp_link_properties (.core_clk(core_clk),
    .reset(reset), .portSelect(i_qwsp_link_if.portSelect),
    .xferEnable(i_qwsp_link_if.xferEnable),
    .readNotWrite(i_qwsp_link_if.readNotWrite),
    .serClk(i_qwsp_link_if.serClk), .dataIn(i_qwsp_link_if.dataIn),
    .cascadeOut(i_qwsp_link_if.cascadeOut));
  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // collects write bytes off the wire on serial clock rises
  always @(posedge core_clk) begin
    if (i_qwsp_link_if.xferEnable && !i_qwsp_link_if.readNotWrite &&
        i_qwsp_link_if.serClk && !clkPrev) begin
      wireSh = {wireSh[6:0], i_qwsp_link_if.dataIn};
      nBits++;
      if (nBits % 8 == 0) wireQ.push_back(wireSh);
    end
    clkPrev = i_qwsp_link_if.serClk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(input logic rd, input logic [1:0] m1,
                     input logic [31:0] w);
    int n;
    logic [7:0] b;
    logic [31:0] exp;
    n = m1 + 1;
    exp = 32'h0000_0000;
    wireQ.delete();
    nBits = 0;
    @(posedge core_clk);
    start <= 1'b1;
    readOp <= rd;
    wordCountM1 <= m1;
    writeWords <= w;
    @(posedge core_clk);
    start <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({31'h0, i_qwsp_link_if.cascadeOut},
      {31'h0, i_qwsp_link_if.dataIn});
    for (int t = 0; t < 2000 && done !== 1'b1; t++) @(posedge core_clk);
    chk({31'h0, done}, 32'h0000_0001);
    if (rd) begin
      for (int k = 0; k < n; k++) begin
        exp = {exp[23:0], 2'(k % 4), model[k % 4][5:0]};
      end
      chk(readWords & (32'hffff_ffff >> (32 - 8 * n)), exp);
    end else begin
      chk(32'(wireQ.size()), 32'(n));
      for (int k = n - 1; k >= 0; k--) begin
        b = w[8 * k +: 8];
        model[b[7:6]] = b[5:0];
        if (wireQ.size() > 0) chk(32'(wireQ.pop_front()), 32'(b));
      end
    end
    repeat (6) @(posedge core_clk);
    chk({8'h00, wp3, wp2, wp1, wp0}, {8'h00, 6'(model[3]),
      6'(model[2]), 6'(model[1]), 6'(model[0])});
    chk({30'h0, atHigh, atLow}, {30'h0, model[0] == 63, model[0] == 0});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    start = 1'b0;
    readOp = 1'b0;
    wordCountM1 = 2'h0;
    writeWords = 32'h0000_0000;
    err_total = 0;
    checks_done = 0;
    nBits = 0;
    wireSh = 8'h00;
    clkPrev = 1'b0;
    for (int i = 0; i < 4; i++) model[i] = 32;
    void'($urandom(32'h798b_c35f));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    run(1'b1, 2'h3, 32'h0000_0000);
    $display("test reset_read done");
    run(1'b0, 2'h3, 32'hff3f_aa00);
    $display("test unordered_write done");
    run(1'b0, 2'h0, 32'h0000_003f);
    run(1'b1, 2'h1, 32'h0000_0000);
    $display("test ends_and_read done");
    for (int i = 0; i < 16; i++) begin
      run(1'($urandom), 2'($urandom), $urandom);
    end
    $display("test random_mix done");
    final_report();
  end
  initial begin
    #400000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
